// ---- verilog/adc_ctrl.sv ----
/*
 Converter control: conversion mode sequencing, result clipping, gain
 selection and the alert/ready comparator, with a classic Wishbone slave.
 Assumes the modulator/filter raises CONV_DONE asynchronously with
 CONV_DATA held stable until the next done edge, and that an I2C engine
 on CLK presents general call bytes and won alert responses as pulses.
*/
// Chosen here: the Wishbone slave port and the placing of the registers.
module adc_ctrl (
   input  wire logic                CLK,            // System clock
   input  wire logic                RST,            // Async reset
   input  wire logic                CE,             // Clock enable
   input  wire logic                WB_CYC_I,       // Bus cycle
   input  wire logic                WB_STB_I,       // Strobe
   input  wire logic                WB_WE_I,        // Write enable
   input  wire logic [7:0]          WB_ADR_I,       // Byte address
   input  wire logic [3:0]          WB_SEL_I,       // Byte lanes
   input  wire logic [31:0]         WB_DAT_I,       // Write data
   output logic      [31:0]         WB_DAT_O,       // Read data
   output logic                     WB_ACK_O,       // Acknowledge
   input  wire logic                CONV_DONE,      // Filter done level
   input  wire logic [19:0]         CONV_DATA,      // Raw filter word
   input  wire logic                GEN_CALL_STB,   // General call byte
   input  wire logic [7:0]          GEN_CALL_CMD,   // Its second byte
   input  wire logic                ALERT_RESP_WON, // Won alert response
   output logic                     CONV_RUN,       // Modulator enable
   output logic      [2:0]          GAIN_SEL,       // Gain code 0..5
   output logic      [2:0]          RATE_SEL,       // Data rate code
   output logic                     ALERT_O,        // Alert pin output
   output logic                     ALERT_OE        // Alert pin pull low
);

   adc_ctrl_pkg::conv_state_type state_ff;
   adc_ctrl_pkg::conv_state_type nxt_state;

   logic [15:0] cfg_ff;
   logic [15:0] result_ff;
   logic [15:0] lo_thr_ff;
   logic [15:0] hi_thr_ff;
   logic [2:0]  hits_ff;
   logic [2:0]  nxt_hits;
   logic        cmp_ff;
   logic        nxt_cmp;
   logic        rdy_lvl_ff;
   logic [9:0]  pulse_ff;
   logic        alert_oe_ff;
   logic        alert_o_ff;
   logic        ack_ff;
   logic [31:0] dat_o_ff;
   logic [2:0]  gain_ff;
   logic [2:0]  rate_ff;
   logic        run_ff;

   // Bus decode
   wire req     = WB_CYC_I & WB_STB_I & ~ack_ff;
   wire wr_req  = req & WB_WE_I;
   wire rd_req  = req & ~WB_WE_I;
   wire hit_res = (WB_ADR_I == adc_ctrl_pkg::ADR_RESULT);
   wire hit_cfg = (WB_ADR_I == adc_ctrl_pkg::ADR_CONFIG);
   wire hit_lo  = (WB_ADR_I == adc_ctrl_pkg::ADR_LO_THR);
   wire hit_hi  = (WB_ADR_I == adc_ctrl_pkg::ADR_HI_THR);

   // Byte-lane merge for the 16-bit registers
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  sel);
      merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
   endfunction : merge

   wire [15:0] cfg_wr   = merge(cfg_ff, WB_DAT_I, WB_SEL_I)
                          & adc_ctrl_pkg::CFG_WMASK;
   wire        cfg_we   = wr_req & hit_cfg;
   wire        lo_we    = wr_req & hit_lo;
   wire        hi_we    = wr_req & hit_hi;
   wire [15:0] cfg_next = cfg_we ? cfg_wr : cfg_ff;

   // Configuration fields
   wire        single   = cfg_ff[adc_ctrl_pkg::CFG_MODE];
   wire        cmode    = cfg_ff[adc_ctrl_pkg::CFG_CMODE];
   wire        pol      = cfg_ff[adc_ctrl_pkg::CFG_POL];
   wire        latch    = cfg_ff[adc_ctrl_pkg::CFG_LATCH];
   wire [1:0]  que      = cfg_ff[adc_ctrl_pkg::CFG_QUE_HI:
                                 adc_ctrl_pkg::CFG_QUE_LO];
   wire [2:0]  gain_fld = cfg_ff[adc_ctrl_pkg::CFG_GAIN_HI:
                                 adc_ctrl_pkg::CFG_GAIN_LO];
   wire        que_on   = (que != adc_ctrl_pkg::QUE_OFF);
   // Codes above the last gain alias onto the highest gain
   wire [2:0]  gain_dec = (gain_fld > adc_ctrl_pkg::GAIN_MAX) ?
                          adc_ctrl_pkg::GAIN_MAX : gain_fld;

   // Soft reset from general call
   wire gcall = GEN_CALL_STB &
                (GEN_CALL_CMD == adc_ctrl_pkg::GCALL_RESET);

   // Conversion completion, crossed from the filter domain
   logic done_rise;
   edge_sync u_done_sync (
      .clk  (CLK),
      .rst  (RST),
      .ce   (CE),
      .din  (CONV_DONE),
      .rise (done_rise)
   );
   wire done_take = done_rise & (state_ff == adc_ctrl_pkg::ST_CONV);

   // Start request counts only when idle; a start bit written while busy falls away
   wire start_req = cfg_we & WB_SEL_I[1] &
                    WB_DAT_I[adc_ctrl_pkg::CFG_START] &
                    (state_ff == adc_ctrl_pkg::ST_IDLE);
   wire start_flag = (state_ff == adc_ctrl_pkg::ST_IDLE);

   // Clipping of the wide filter word
   wire signed [19:0] raw      = $signed(CONV_DATA);
   wire signed [19:0] raw_max  = 20'sh07FFF;
   wire signed [19:0] raw_min  = -20'sh08000;
   wire        [15:0] new_code = (raw > raw_max) ? adc_ctrl_pkg::CODE_MAX :
                                 (raw < raw_min) ? adc_ctrl_pkg::CODE_MIN :
                                 CONV_DATA[15:0];

   // Comparator evaluation of the newest code
   wire beyond_hi = $signed(new_code) > $signed(hi_thr_ff);
   wire below_lo  = $signed(new_code) < $signed(lo_thr_ff);
   wire beyond    = cmode ? (beyond_hi | below_lo) : beyond_hi;
   wire [2:0] hits_inc = (hits_ff == adc_ctrl_pkg::HITS_CAP) ?
                         hits_ff : hits_ff + 3'h1;
   wire [2:0] hits_need = (que == 2'h0) ? 3'h1 :
                          (que == 2'h1) ? 3'h2 : 3'h4;
   wire cmp_set   = done_take & beyond & (hits_inc >= hits_need);
   wire cmp_fall  = cmode ? ~beyond : below_lo;
   wire latch_clr = latch & ((rd_req & hit_res) | ALERT_RESP_WON);

   // Conversion-ready mode
   wire rdy_mode  = hi_thr_ff[15] & ~lo_thr_ff[15];
   wire asserted  = rdy_mode ? (rdy_lvl_ff | (pulse_ff != 10'h000)) :
                    cmp_ff;
   // Open drain: pull low when asserted and active low, or idle and high
   wire nxt_oe    = que_on & (asserted ^ pol);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         adc_ctrl_pkg::ST_IDLE: begin
            if (!single || start_req)
               nxt_state = adc_ctrl_pkg::ST_CONV;
         end
         adc_ctrl_pkg::ST_CONV: begin
            if (done_take && single)
               nxt_state = adc_ctrl_pkg::ST_IDLE;
         end
      endcase
   end

   always_comb begin
      nxt_hits = hits_ff;
      nxt_cmp  = cmp_ff;
      if (!que_on) begin
         nxt_hits = 3'h0;
         nxt_cmp  = 1'b0;
      end else begin
         if (done_take)
            nxt_hits = beyond ? hits_inc : 3'h0;
         if (cmp_set)
            nxt_cmp = 1'b1;
         else if (latch_clr)
            nxt_cmp = 1'b0;
         else if (done_take && cmp_fall && !latch)
            nxt_cmp = 1'b0;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_ff <= adc_ctrl_pkg::ST_IDLE;
      end else if (CE) begin
         if (gcall)
            state_ff <= adc_ctrl_pkg::ST_IDLE;
         else
            state_ff <= nxt_state;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cfg_ff    <= adc_ctrl_pkg::CFG_RESET & adc_ctrl_pkg::CFG_WMASK;
         lo_thr_ff <= adc_ctrl_pkg::LO_RESET;
         hi_thr_ff <= adc_ctrl_pkg::HI_RESET;
      end else if (CE) begin
         if (gcall) begin
            cfg_ff    <= adc_ctrl_pkg::CFG_RESET & adc_ctrl_pkg::CFG_WMASK;
            lo_thr_ff <= adc_ctrl_pkg::LO_RESET;
            hi_thr_ff <= adc_ctrl_pkg::HI_RESET;
         end else begin
            cfg_ff <= cfg_next;
            if (lo_we)
               lo_thr_ff <= merge(lo_thr_ff, WB_DAT_I, WB_SEL_I);
            if (hi_we)
               hi_thr_ff <= merge(hi_thr_ff, WB_DAT_I, WB_SEL_I);
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         result_ff <= 16'h0000;
      end else if (CE) begin
         if (gcall)
            result_ff <= 16'h0000;
         else if (done_take)
            result_ff <= new_code;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         hits_ff <= 3'h0;
         cmp_ff  <= 1'b0;
      end else if (CE) begin
         hits_ff <= gcall ? 3'h0 : nxt_hits;
         cmp_ff  <= gcall ? 1'b0 : nxt_cmp;
      end
   end

   // Ready indication: a timed pulse when continuous, a level when single
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pulse_ff   <= 10'h000;
         rdy_lvl_ff <= 1'b0;
      end else if (CE) begin
         if (gcall) begin
            pulse_ff   <= 10'h000;
            rdy_lvl_ff <= 1'b0;
         end else begin
            if (done_take && !single)
               pulse_ff <= adc_ctrl_pkg::RDY_PULSE_CYC;
            else if (pulse_ff != 10'h000)
               pulse_ff <= pulse_ff - 10'h001;
            if (done_take && single)
               rdy_lvl_ff <= 1'b1;
            else if (start_req || !single)
               rdy_lvl_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         alert_oe_ff <= 1'b0;
         alert_o_ff  <= 1'b0;
         gain_ff     <= 3'h0;
         rate_ff     <= 3'h0;
         run_ff      <= 1'b0;
      end else if (CE) begin
         alert_oe_ff <= nxt_oe;
         alert_o_ff  <= 1'b0;
         gain_ff     <= gain_dec;
         rate_ff     <= cfg_ff[adc_ctrl_pkg::CFG_RATE_HI:
                               adc_ctrl_pkg::CFG_RATE_LO];
         run_ff      <= (nxt_state == adc_ctrl_pkg::ST_CONV) & ~gcall;
      end
   end

   // Wishbone answer: one wait state, unmapped reads return zero
   wire [15:0] rd_mux = hit_res ? result_ff :
                        hit_cfg ? {start_flag, cfg_ff[14:0]} :
                        hit_lo  ? lo_thr_ff :
                        hit_hi  ? hi_thr_ff : 16'h0000;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ack_ff   <= 1'b0;
         dat_o_ff <= 32'h0000_0000;
      end else if (CE) begin
         ack_ff   <= req;
         dat_o_ff <= rd_req ? {16'h0000, rd_mux} : 32'h0000_0000;
      end
   end

   assign WB_ACK_O = ack_ff;
   assign WB_DAT_O = dat_o_ff;
   assign CONV_RUN = run_ff;
   assign GAIN_SEL = gain_ff;
   assign RATE_SEL = rate_ff;
   assign ALERT_O  = alert_o_ff;
   assign ALERT_OE = alert_oe_ff;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST || !CE);

   property p_clip_high;
      done_take && !gcall && (raw > raw_max) |=> result_ff == 16'h7FFF;
   endproperty
   a_clip_high: assert property (p_clip_high)
      else $error("result not clipped to top code");

   property p_code_pass;
      done_take && !gcall && (raw <= raw_max) && (raw >= raw_min)
         |=> result_ff == $past(CONV_DATA[15:0]);
   endproperty
   a_code_pass: assert property (p_code_pass)
      else $error("in-range code altered");

   property p_start_busy;
      start_req && single && !gcall |=> !start_flag ##1 CONV_RUN;
   endproperty
   a_start_busy: assert property (p_start_busy)
      else $error("start flag not busy after start");

   property p_single_done;
      done_take && single && !gcall |=> start_flag && !CONV_RUN;
   endproperty
   a_single_done: assert property (p_single_done)
      else $error("single shot did not return to idle");

   property p_busy_write;
      (state_ff == adc_ctrl_pkg::ST_CONV) && cfg_we && !done_take && !gcall
         |=> state_ff == adc_ctrl_pkg::ST_CONV;
   endproperty
   a_busy_write: assert property (p_busy_write)
      else $error("busy write disturbed conversion");

   property p_continuous;
      done_take && !single && !gcall |=> state_ff == adc_ctrl_pkg::ST_CONV;
   endproperty
   a_continuous: assert property (p_continuous)
      else $error("continuous mode stopped converting");

   property p_gcall;
      gcall |=> (cfg_ff == (adc_ctrl_pkg::CFG_RESET & adc_ctrl_pkg::CFG_WMASK))
                && start_flag ##1 !CONV_RUN;
   endproperty
   a_gcall: assert property (p_gcall)
      else $error("general call reset incomplete");

   property p_pulse;
      done_take && !single && !gcall
         |=> pulse_ff == adc_ctrl_pkg::RDY_PULSE_CYC ##1
             pulse_ff == adc_ctrl_pkg::RDY_PULSE_CYC - 10'h001;
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("ready pulse length wrong");

   property p_latch_hold;
      cmp_ff && latch && que_on && !latch_clr && !gcall |=> cmp_ff;
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("latched alert dropped");

   c_single: cover property (start_req ##[1:1000] done_take);
   c_alert:  cover property (cmp_set ##1 cmp_ff);
   c_pulse:  cover property (done_take && !single && rdy_mode);

endmodule : adc_ctrl

// ---- verilog/adc_ctrl_pkg.sv ----
/*
 Constants, field layout and types shared by the converter control block.
 Assumes a 100 MHz system clock and a classic Wishbone register port.
*/
package adc_ctrl_pkg;

   localparam int          ADR_W        = 8;
   localparam logic [7:0]  ADR_RESULT   = 8'h00;
   localparam logic [7:0]  ADR_CONFIG   = 8'h04;
   localparam logic [7:0]  ADR_LO_THR   = 8'h08;
   localparam logic [7:0]  ADR_HI_THR   = 8'h0C;

   localparam int          CFG_START    = 15;
   localparam int          CFG_GAIN_HI  = 11;
   localparam int          CFG_GAIN_LO  = 9;
   localparam int          CFG_MODE     = 8;
   localparam int          CFG_RATE_HI  = 7;
   localparam int          CFG_RATE_LO  = 5;
   localparam int          CFG_CMODE    = 4;
   localparam int          CFG_POL      = 3;
   localparam int          CFG_LATCH    = 2;
   localparam int          CFG_QUE_HI   = 1;
   localparam int          CFG_QUE_LO   = 0;

   localparam logic [15:0] CFG_RESET    = 16'h8583;
   localparam logic [15:0] CFG_WMASK    = 16'h0FFF;
   localparam logic [15:0] LO_RESET     = 16'h8000;
   localparam logic [15:0] HI_RESET     = 16'h7FFF;
   localparam logic [15:0] CODE_MAX     = 16'h7FFF;
   localparam logic [15:0] CODE_MIN     = 16'h8000;

   localparam int          RAW_W        = 20;
   localparam logic [2:0]  GAIN_MAX     = 3'h5;
   localparam logic [1:0]  QUE_OFF      = 2'h3;
   localparam logic [2:0]  HITS_CAP     = 3'h4;
   localparam logic [7:0]  GCALL_RESET  = 8'h06;

   localparam int          CLK_MHZ      = 100;
   localparam int          RDY_PULSE_NS = 8000;
   localparam int          RDY_CYC_INT  = RDY_PULSE_NS * CLK_MHZ / 1000;
   localparam logic [9:0]  RDY_PULSE_CYC = RDY_CYC_INT[9:0];

   typedef enum logic {ST_IDLE, ST_CONV} conv_state_type;

endpackage : adc_ctrl_pkg

// ---- verilog/edge_sync.sv ----
/*
 Two-flop synchroniser with rising-edge detection on the synchronised level.
 Assumes the input is a level from outside the clock domain.
*/
module edge_sync (
   input  wire logic clk,    // System clock
   input  wire logic rst,    // Async reset, active high
   input  wire logic ce,     // Clock enable
   input  wire logic din,    // Asynchronous level
   output logic      rise    // One-cycle pulse on rising edge
);
   logic meta_ff;
   logic sync_ff;
   logic prev_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else if (ce) begin
         meta_ff <= din;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign rise = sync_ff & ~prev_ff;

endmodule : edge_sync

// ---- dv/conv_model.sv ----
/*
 Behavioural modulator and filter model standing behind the block.
 Assumes run comes from the block and the bench supplies the next word.
*/
module conv_model #(
   parameter int TICKS = 120                 // Link clocks per conversion
) (
   input  wire logic        lclk,            // Link clock, 80 ns
   input  wire logic        rst,             // Async reset, active high
   input  wire logic        run,             // Modulator enable
   input  wire logic [19:0] next_word,       // Word for the next result
   output logic             done,            // Completion level
   output logic      [19:0] word             // Raw filter word
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   // Word is inverted once done drops, so a late sample never looks valid
   always_ff @(posedge lclk or posedge rst) begin
      if (rst) begin
         cnt <= 0;
         done <= 1'b0;
         word <= 20'h00000;
      end else if (!run) begin
         cnt <= 0;
         done <= 1'b0;
         if (done) word <= ~word;
      end else begin
         cnt <= (cnt == TICKS + 4) ? 0 : cnt + 1;
         if (cnt == TICKS) begin
            done <= 1'b1;
            word <= next_word;
         end
         if (cnt == TICKS + 4) begin
            done <= 1'b0;
            word <= ~word;
         end
      end
   end
endmodule : conv_model

// ---- dv/adc_ctrl_tb_top.sv ----
/*
 Self-checking bench for the converter control block: Wishbone tasks,
 a modulator model on an 80 ns link clock and table-driven scenarios.
 Assumes the package register map and the 800-cycle ready pulse.
*/
module adc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] A_RES = adc_ctrl_pkg::ADR_RESULT;
   localparam logic [7:0] A_CFG = adc_ctrl_pkg::ADR_CONFIG;
   localparam logic [7:0] A_LO  = adc_ctrl_pkg::ADR_LO_THR;
   localparam logic [7:0] A_HI  = adc_ctrl_pkg::ADR_HI_THR;
   localparam int         P     = int'(adc_ctrl_pkg::RDY_PULSE_CYC);
   logic        clk, rst, lclk, cyc, stb, we, gstb, won;
   logic        ack, done, run, alert, alert_oe, en;
   logic [7:0]  adr, gcmd;
   logic [31:0] wdat, rdat, q;
   logic [19:0] cdat, nxt;
   logic [2:0]  gain, rate;
   int          fail_count, n_checks, i, n;
   logic [19:0] cr [9] = '{20'h08000, 20'h7FFFF, 20'h07FFF, 20'h00001,
      20'h00000, 20'hFFFFF, 20'hF8000, 20'h80000, 20'hF7FFF};
   logic [15:0] ce [9] = '{16'h7FFF, 16'h7FFF, 16'h7FFF, 16'h0001,
      16'h0000, 16'hFFFF, 16'h8000, 16'h8000, 16'h8000};
   logic [7:0]  tc [17] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h90, 8'h90,
      8'h90, 8'h90, 8'h91, 8'h91, 8'h91, 8'h91, 8'h98, 8'h98, 8'h93,
      8'h94, 8'h94};
   logic [19:0] tr [17] = '{20'hFFF00, 20'h00300, 20'h00150, 20'h00050,
      20'h00300, 20'h00150, 20'h00050, 20'h00150, 20'h00300, 20'h00300,
      20'h00150, 20'h00300, 20'h00300, 20'h00150, 20'h00300, 20'h00300,
      20'h00150};
   // Expected alert enable per table row, row 0 in the leftmost bit
   logic [0:16] te = 17'h0D48B;

   adc_ctrl u_dut (
      .CLK(clk), .RST(rst), .CE(en), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(wdat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .CONV_DONE(done),
      .CONV_DATA(cdat), .GEN_CALL_STB(gstb), .GEN_CALL_CMD(gcmd),
      .ALERT_RESP_WON(won), .CONV_RUN(run), .GAIN_SEL(gain),
      .RATE_SEL(rate), .ALERT_O(alert), .ALERT_OE(alert_oe));

   conv_model #(.TICKS(120)) u_mod (
      .lclk(lclk), .rst(rst), .run(run), .next_word(nxt), .done(done),
      .word(cdat));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Link clock phase is offset so its edges never line up with CLK
   initial begin
      lclk = 1'b0;
      #13;
      forever #40 lclk = ~lclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [15:0] d);
      int k;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {16'h0000, d};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1);
      q = rdat;
      chk(k, 2);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      wb(1'b0, a, 16'h0000);
      chk(q, {16'h0000, exp});
   endtask : rd

   // Single-shot conversion with start flag polled, as a host would do
   task automatic conv1(input logic [19:0] raw, input logic [7:0] lo8,
                        input logic again);
      int k;
      nxt <= raw;
      wb(1'b1, A_CFG, {8'h85, lo8});
      rd(A_CFG, {8'h05, lo8});
      if (again) wb(1'b1, A_CFG, {8'h85, lo8});
      k = 0;
      do begin
         wb(1'b0, A_CFG, 16'h0000);
         k++;
      end while (q[15] !== 1'b1 && k < 600);
      chk(q, {16'h0000, 8'h85, lo8});
      repeat (3) @(negedge clk);
      chk(run, 1'b0);
   endtask : conv1

   task automatic gcall(input logic [7:0] c);
      @(posedge clk);
      gstb <= 1'b1;
      gcmd <= c;
      @(posedge clk);
      gstb <= 1'b0;
   endtask : gcall

   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   initial begin
      repeat (90000) @(posedge clk);
      fail_count++;
      end_of_test();
   end

   initial begin
      rst = 1'b1;
      {cyc, stb, we, gstb, won} = 5'h00;
      en = 1'b1;
      adr = 8'h00;
      gcmd = 8'h00;
      wdat = 32'h0000_0000;
      nxt = 20'h00000;
      fail_count = 0;
      n_checks = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(A_CFG, 16'h8583);
      rd(A_LO, 16'h8000);
      rd(A_HI, 16'h7FFF);
      rd(8'h10, 16'h0000);
      chk({rate, alert, alert_oe}, 5'h10);
      for (i = 0; i < 8; i++) begin
         wb(1'b1, A_CFG, {4'h0, 3'(i), 9'h183});
         @(negedge clk);
         chk(gain, (i > 5) ? 5 : i);
      end
      for (i = 0; i < 9; i++) begin
         conv1(cr[i], 8'h83, 1'b0);
         rd(A_RES, ce[i]);
      end
      conv1(20'h00444, 8'h83, 1'b1);
      repeat (1500) @(negedge clk);
      chk(run, 1'b0);
      rd(A_RES, 16'h0444);
      wb(1'b1, A_LO, 16'h0100);
      wb(1'b1, A_HI, 16'h0200);
      for (i = 0; i < 17; i++) begin
         conv1(tr[i], tc[i], 1'b0);
         chk(alert_oe, te[i]);
      end
      rd(A_RES, 16'h0150);
      repeat (3) @(negedge clk);
      chk(alert_oe, 1'b0);
      conv1(20'h00300, 8'h94, 1'b0);
      chk(alert_oe, 1'b1);
      @(posedge clk);
      won <= 1'b1;
      @(posedge clk);
      won <= 1'b0;
      repeat (3) @(negedge clk);
      chk(alert_oe, 1'b0);
      wb(1'b1, A_HI, 16'h8000);
      wb(1'b1, A_LO, 16'h0000);
      conv1(20'h00123, 8'h94, 1'b0);
      chk(alert_oe, 1'b1);
      nxt <= 20'h01111;
      wb(1'b1, A_CFG, 16'h0480);
      // Leaving single shot drops the ready level before the first pulse
      repeat (3) @(negedge clk);
      chk(alert_oe, 1'b0);
      for (i = 0; i < 2; i++) begin
         n = 0;
         while (alert_oe !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
         end
         // A frozen span inside the pulse must stretch it by that span
         if (i == 1) begin
            @(posedge clk);
            en <= 1'b0;
            repeat (100) @(posedge clk);
            en <= 1'b1;
         end
         n = 0;
         while (alert_oe === 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
         end
         chk(n >= P - 1 && n <= P + 1, 1);
         chk(run, 1'b1);
         rd(A_RES, i ? 16'h2222 : 16'h1111);
         nxt <= 20'h02222;
      end
      gcall(8'h05);
      rd(A_CFG, 16'h0480);
      gcall(adc_ctrl_pkg::GCALL_RESET);
      rd(A_CFG, 16'h8583);
      rd(A_HI, 16'h7FFF);
      chk(run, 1'b0);
      end_of_test();
   end
endmodule : adc_ctrl_tb_top
